// *** cpu8_decode_pkg.sv ***
// Package for the accumulator arithmetic, logical and rotate decoder.
// Assumes one processor clock; all users refer to names as cpu8_decode_pkg::name.
package cpu8_decode_pkg;

    // Width of the cycle budget field
    localparam int CYCLE_W = 4;

    // Clock-cycle budgets per instruction form
    localparam logic [CYCLE_W-1:0] CYC_REG        = 4'h4;
    localparam logic [CYCLE_W-1:0] CYC_MEM        = 4'h7;
    localparam logic [CYCLE_W-1:0] CYC_IMM        = 4'h7;
    localparam logic [CYCLE_W-1:0] CYC_PAIR       = 4'hA;
    localparam logic [CYCLE_W-1:0] CYC_ROTATE     = 4'h4;
    localparam logic [CYCLE_W-1:0] CYC_COND_SHORT = 4'h6;
    localparam logic [CYCLE_W-1:0] CYC_COND_LONG  = 4'hC;
    localparam logic [CYCLE_W-1:0] CYC_NONE       = 4'h0;

    // Three-bit register operand codes
    localparam logic [2:0] REG_B   = 3'h0;
    localparam logic [2:0] REG_C   = 3'h1;
    localparam logic [2:0] REG_D   = 3'h2;
    localparam logic [2:0] REG_E   = 3'h3;
    localparam logic [2:0] REG_H   = 3'h4;
    localparam logic [2:0] REG_L   = 3'h5;
    localparam logic [2:0] REG_MEM = 3'h6;
    localparam logic [2:0] REG_ACC = 3'h7;

    // Register pair codes for the pair addition
    localparam logic [1:0] PAIR_BC = 2'h0;
    localparam logic [1:0] PAIR_DE = 2'h1;
    localparam logic [1:0] PAIR_HL = 2'h2;
    localparam logic [1:0] PAIR_SP = 2'h3;

    // Operation; codes 0..7 follow opcode bits 5:3 of the accumulator groups
    typedef enum logic [3:0] {
        OP_ADD          = 4'h0,
        OP_ADC          = 4'h1,
        OP_SUB          = 4'h2,
        OP_MINUS_BORROW = 4'h3,
        OP_AND          = 4'h4,
        OP_XOR          = 4'h5,
        OP_OR           = 4'h6,
        OP_COMPARE      = 4'h7,
        OP_ROT_L_CIRC   = 4'h8,
        OP_ROT_R_CIRC   = 4'h9,
        OP_ROT_L_CARRY  = 4'hA,
        OP_ROT_R_CARRY  = 4'hB,
        OP_PAIR_ADD     = 4'hC,
        OP_COND_TIMED   = 4'hD,
        OP_NONE         = 4'hF
    } alu_op_t;

    // Where the second operand comes from
    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_REG  = 3'h1,
        SRC_MEM  = 3'h2,
        SRC_IMM  = 3'h3,
        SRC_PAIR = 3'h4
    } operand_src_t;

    // Condition flags
    typedef struct packed {
        logic sign;
        logic zero;
        logic parity;
        logic carry;
    } flags_t;

    // Decoded instruction
    typedef struct packed {
        logic               known;
        alu_op_t            op;
        operand_src_t       src;
        logic [2:0]         source_field;
        logic [1:0]         pair_sel;
        logic               writes_acc;
        logic [CYCLE_W-1:0] cycles;
    } decode_t;

endpackage

// *** acc_alu_unit.sv ***
// Accumulator arithmetic, logic and rotate unit, purely combinational.
// Assumes the caller registers its outputs and supplies the decoded operation.
`timescale 1ns/1ns
module acc_alu_unit (
    // Operation and operands
    input  wire cpu8_decode_pkg::alu_op_t op,
    input  wire logic [7:0]               acc,
    input  wire logic [7:0]               operand,
    input  wire cpu8_decode_pkg::flags_t  flags_in,
    // Results
    output cpu8_decode_pkg::flags_t       flags_out,
    output logic [7:0]                    result
);

    logic [8:0] wide;
    logic       use_carry;

    // Carry-in only for the with-carry and with-borrow forms
    assign use_carry = (op == cpu8_decode_pkg::OP_ADC) || (op == cpu8_decode_pkg::OP_MINUS_BORROW);

    // Compute result and flags
    always_comb begin
        wide      = 9'h000;
        result    = acc;
        flags_out = flags_in;
        unique case (op)
            cpu8_decode_pkg::OP_ADD, cpu8_decode_pkg::OP_ADC: begin
                wide = {1'b0, acc} + {1'b0, operand} + {8'h00, use_carry & flags_in.carry};
            end
            cpu8_decode_pkg::OP_SUB, cpu8_decode_pkg::OP_MINUS_BORROW, cpu8_decode_pkg::OP_COMPARE: begin
                // Top bit of the 9-bit difference is the borrow
                wide = {1'b0, acc} - {1'b0, operand} - {8'h00, use_carry & flags_in.carry};
            end
            cpu8_decode_pkg::OP_AND: wide = {1'b0, acc & operand};
            cpu8_decode_pkg::OP_XOR: wide = {1'b0, acc ^ operand};
            cpu8_decode_pkg::OP_OR:  wide = {1'b0, acc | operand};
            default: wide = 9'h000;
        endcase

        unique case (op)
            cpu8_decode_pkg::OP_ADD, cpu8_decode_pkg::OP_ADC, cpu8_decode_pkg::OP_SUB,
            cpu8_decode_pkg::OP_MINUS_BORROW, cpu8_decode_pkg::OP_AND, cpu8_decode_pkg::OP_XOR,
            cpu8_decode_pkg::OP_OR, cpu8_decode_pkg::OP_COMPARE: begin
                result           = wide[7:0];
                flags_out.carry  = wide[8];
                flags_out.zero   = (wide[7:0] == 8'h00);
                flags_out.sign   = wide[7];
                flags_out.parity = ~^wide[7:0];
                if (op == cpu8_decode_pkg::OP_COMPARE) begin
                    result = acc;
                end
            end
            // Circular rotations copy the bit shifted out into carry
            cpu8_decode_pkg::OP_ROT_L_CIRC: begin
                result          = {acc[6:0], acc[7]};
                flags_out.carry = acc[7];
            end
            cpu8_decode_pkg::OP_ROT_R_CIRC: begin
                result          = {acc[0], acc[7:1]};
                flags_out.carry = acc[0];
            end
            // Through-carry rotations form a nine-bit ring
            cpu8_decode_pkg::OP_ROT_L_CARRY: begin
                result          = {acc[6:0], flags_in.carry};
                flags_out.carry = acc[7];
            end
            cpu8_decode_pkg::OP_ROT_R_CARRY: begin
                result          = {flags_in.carry, acc[7:1]};
                flags_out.carry = acc[0];
            end
            default: begin
                result    = acc;
                flags_out = flags_in;
            end
        endcase
    end

endmodule

// *** cpu8_alu_logic_rotate_decode.sv ***
// Opcode decoder and cycle budgeter for accumulator arithmetic, pair add,
// subtract, logical, compare and rotate instructions.
// Assumes fetch and datapath run on the same clock and present the opcode
// together with the accumulator, the fetched operand and the current flags.
`timescale 1ns/1ns
module cpu8_alu_logic_rotate_decode (
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    // Request from fetch
    input  wire logic                     op_valid,
    input  wire logic [7:0]               opcode,
    input  wire logic                     cond_met,
    // Operands from the datapath
    input  wire logic [7:0]               acc_in,
    input  wire logic [7:0]               operand_in,
    input  wire cpu8_decode_pkg::flags_t  flags_in,
    // Registered answer
    output logic                          dec_valid,
    output cpu8_decode_pkg::decode_t      dec,
    output logic [7:0]                    acc_out,
    output cpu8_decode_pkg::flags_t       flags_out
);

    cpu8_decode_pkg::decode_t next_dec;
    cpu8_decode_pkg::flags_t  alu_flags;
    logic [7:0]               alu_result;

    // Decode the opcode into operation, operand source and cycle budget
    always_comb begin
        next_dec              = '0;
        next_dec.known        = 1'b1;
        next_dec.op           = cpu8_decode_pkg::OP_NONE;
        next_dec.src          = cpu8_decode_pkg::SRC_NONE;
        next_dec.source_field = opcode[2:0];
        next_dec.pair_sel     = opcode[5:4];
        next_dec.writes_acc   = 1'b0;
        next_dec.cycles       = cpu8_decode_pkg::CYC_NONE;
        casez (opcode)
            // Register and memory accumulator groups, op in bits 5:3
            8'b10??????: begin
                next_dec.op         = cpu8_decode_pkg::alu_op_t'({1'b0, opcode[5:3]});
                next_dec.writes_acc = (opcode[5:3] != 3'h7);
                if (opcode[2:0] == cpu8_decode_pkg::REG_MEM) begin
                    next_dec.src    = cpu8_decode_pkg::SRC_MEM;
                    next_dec.cycles = cpu8_decode_pkg::CYC_MEM;
                end else begin
                    next_dec.src    = cpu8_decode_pkg::SRC_REG;
                    next_dec.cycles = cpu8_decode_pkg::CYC_REG;
                end
            end
            // Immediate accumulator group
            8'b11???110: begin
                next_dec.op         = cpu8_decode_pkg::alu_op_t'({1'b0, opcode[5:3]});
                next_dec.writes_acc = (opcode[5:3] != 3'h7);
                next_dec.src        = cpu8_decode_pkg::SRC_IMM;
                next_dec.cycles     = cpu8_decode_pkg::CYC_IMM;
            end
            // Register pair added into HL
            8'b00??1001: begin
                next_dec.op     = cpu8_decode_pkg::OP_PAIR_ADD;
                next_dec.src    = cpu8_decode_pkg::SRC_PAIR;
                next_dec.cycles = cpu8_decode_pkg::CYC_PAIR;
            end
            // Accumulator rotations
            8'b00000111: begin
                next_dec.op         = cpu8_decode_pkg::OP_ROT_L_CIRC;
                next_dec.writes_acc = 1'b1;
                next_dec.cycles     = cpu8_decode_pkg::CYC_ROTATE;
            end
            8'b00010111: begin
                next_dec.op         = cpu8_decode_pkg::OP_ROT_L_CARRY;
                next_dec.writes_acc = 1'b1;
                next_dec.cycles     = cpu8_decode_pkg::CYC_ROTATE;
            end
            8'b00001111: begin
                next_dec.op         = cpu8_decode_pkg::OP_ROT_R_CIRC;
                next_dec.writes_acc = 1'b1;
                next_dec.cycles     = cpu8_decode_pkg::CYC_ROTATE;
            end
            8'b00011111: begin
                next_dec.op         = cpu8_decode_pkg::OP_ROT_R_CARRY;
                next_dec.writes_acc = 1'b1;
                next_dec.cycles     = cpu8_decode_pkg::CYC_ROTATE;
            end
            // Conditional returns: budget follows the tested condition
            8'b11???000: begin
                next_dec.op     = cpu8_decode_pkg::OP_COND_TIMED;
                next_dec.cycles = cond_met ? cpu8_decode_pkg::CYC_COND_LONG
                                           : cpu8_decode_pkg::CYC_COND_SHORT;
            end
            default: begin
                next_dec.known = 1'b0;
            end
        endcase
    end

    // Result and flag computation
    acc_alu_unit u_alu (
        .op        (next_dec.op),
        .acc       (acc_in),
        .operand   (operand_in),
        .flags_in  (flags_in),
        .flags_out (alu_flags),
        .result    (alu_result)
    );

    // Answer valid strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dec_valid <= 1'b0;
        end else begin
            dec_valid <= op_valid;
        end
    end

    // Decode register, loaded on each request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dec <= '0;
        end else if (op_valid) begin
            dec <= next_dec;
        end
    end

    // Accumulator and flags; compare, pair add, conditional and unknown keep A, others take the ALU result
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc_out   <= 8'h00;
            flags_out <= '0;
        end else if (op_valid) begin
            acc_out   <= next_dec.writes_acc ? alu_result : acc_in;
            flags_out <= alu_flags;
        end
    end

endmodule

// *** cpu8_decode_properties.sv ***
// Checker of decode timing and operand relations at the decoder's ports.
// Assumes it is bound to the decoder top and sees only its ports.
`timescale 1ns/1ns
module decode_checker (
    // Clock, reset and request
    input wire logic                    clock,
    input wire logic                    rst_n,
    input wire logic                    op_valid,
    input wire logic [7:0]              opcode,
    input wire logic                    cond_met,
    input wire logic [7:0]              acc_in,
    input wire logic [7:0]              operand_in,
    input wire cpu8_decode_pkg::flags_t flags_in,
    // Answer
    input wire logic                    dec_valid,
    input wire cpu8_decode_pkg::decode_t dec,
    input wire logic [7:0]              acc_out,
    input wire cpu8_decode_pkg::flags_t flags_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Conditional return requested, whether taken or not
    sequence cond_take;
        op_valid && opcode[7:6] == 2'h3 && opcode[2:0] == 3'h0;
    endsequence
    answer_after_a: assert property (op_valid |=> dec_valid)
        else $error("answer missing after request");
    no_spurious_a: assert property (!op_valid |=> !dec_valid && $stable(acc_out))
        else $error("answer without request");
    mem_seven_a: assert property (op_valid && opcode[7:6] == 2'h2 && opcode[2:0] == 3'h6 |=> dec.cycles == 4'h7)
        else $error("memory operand budget wrong");
    reg_four_a: assert property (op_valid && opcode[7:6] == 2'h2 && opcode[2:0] != 3'h6
        |=> dec.cycles == 4'h4 && dec.source_field == $past(opcode[2:0]))
        else $error("register operand decode wrong");
    imm_seven_a: assert property (op_valid && opcode[7:6] == 2'h3 && opcode[2:0] == 3'h6 |=> dec.cycles == 4'h7)
        else $error("immediate budget wrong");
    pair_add_a: assert property (op_valid && opcode[7:6] == 2'h0 && opcode[3:0] == 4'h9
        |=> dec.cycles == 4'hA && dec.pair_sel == $past(opcode[5:4]))
        else $error("pair add decode wrong");
    rotate_kind_a: assert property (op_valid && opcode[7:5] == 3'h0 && opcode[2:0] == 3'h7
        |=> dec.cycles == 4'h4 && dec.op == {2'h2, $past(opcode[4:3])})
        else $error("rotate decode wrong");
    compare_keeps_a: assert property (op_valid && opcode[7:3] == 5'h17 |=> acc_out == $past(acc_in))
        else $error("compare changed accumulator");
    rlc_ring_a: assert property (op_valid && opcode == 8'h07
        |=> {acc_out, flags_out.carry} == {$past(acc_in[6:0]), $past(acc_in[7]), $past(acc_in[7])})
        else $error("circular rotate wrong");
    borrow_sub_a: assert property (op_valid && opcode[7:3] == 5'h13 |=> {flags_out.carry, acc_out}
        == {1'b0, $past(acc_in)} - {1'b0, $past(operand_in)} - 9'($past(flags_in.carry)))
        else $error("borrow subtract wrong");
    cond_long_a: assert property (cond_take ##0 cond_met |=> dec.cycles == 4'hC)
        else $error("taken condition budget wrong");
    cond_short_a: assert property (cond_take ##0 !cond_met |=> dec.cycles == 4'h6)
        else $error("untaken condition budget wrong");
endmodule

bind cpu8_alu_logic_rotate_decode decode_checker chk_u (.clock(clock), .rst_n(rst_n), .op_valid(op_valid),
    .opcode(opcode), .cond_met(cond_met), .acc_in(acc_in), .operand_in(operand_in), .flags_in(flags_in),
    .dec_valid(dec_valid), .dec(dec), .acc_out(acc_out), .flags_out(flags_out));

// *** fetch_model.sv ***
// Fetch and datapath model that presents one opcode with its operands.
// Assumes the bench loads it one cycle before the decoder should take it.
`timescale 1ns/1ns
module fetch_model (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Load from the bench
    input  wire logic             load,
    input  wire logic [7:0]       ld_opcode,
    input  wire logic [7:0]       ld_acc,
    input  wire logic [7:0]       ld_operand,
    input  wire logic             ld_carry,
    input  wire logic             ld_cond,
    // Request to the decoder
    output logic                  op_valid,
    output logic [7:0]            opcode,
    output logic [7:0]            acc_in,
    output logic [7:0]            operand_in,
    output cpu8_decode_pkg::flags_t flags_in,
    output logic                  cond_met
);
    // Idle cycles clear op_valid and invert every other field so stale values never look valid
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            {op_valid, opcode, acc_in, operand_in, flags_in, cond_met} <= '0;
        else if (load)
            {op_valid, opcode, acc_in, operand_in, flags_in, cond_met} <=
                {1'b1, ld_opcode, ld_acc, ld_operand, 3'h0, ld_carry, ld_cond};
        else
            {op_valid, opcode, acc_in, operand_in, flags_in, cond_met} <=
                {1'b0, ~opcode, ~acc_in, ~operand_in, ~flags_in, ~cond_met};
    end
endmodule

// *** cpu8_alu_logic_rotate_decode_tb.sv ***
// Self-checking bench for the opcode decoder, fed through the fetch model.
// Assumes the checker is bound to the decoder by its own file.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module cpu8_alu_logic_rotate_decode_tb;
    typedef struct packed {
        logic [7:0] opc, a, b;
        logic c;
        logic [3:0] op;
        logic [2:0] src;
        logic [3:0] cyc;
        logic [7:0] r;
        logic co;
    } row_t;
    logic clock = 1'b0, rst_n = 1'b0, load = 1'b0, ld_carry = 1'b0, ld_cond = 1'b0;
    logic [7:0] ld_opcode = 8'h00, ld_acc = 8'h00, ld_operand = 8'h00, opcode, acc_in, operand_in, acc_out;
    logic op_valid, cond_met, dec_valid;
    cpu8_decode_pkg::flags_t flags_in, flags_out;
    cpu8_decode_pkg::decode_t dec;
    int bad_count = 0, tests_run = 0;
    row_t rows [25] = '{
        '{8'h8E,8'h10,8'h05,1'b1,4'h1,3'h2,4'h7,8'h16,1'b0},
        '{8'hC6,8'h10,8'h05,1'b1,4'h0,3'h3,4'h7,8'h15,1'b0},
        '{8'hCE,8'hFF,8'h00,1'b1,4'h1,3'h3,4'h7,8'h00,1'b1},
        '{8'h19,8'h33,8'h00,1'b0,4'hC,3'h4,4'hA,8'h33,1'b0},
        '{8'h39,8'h33,8'h00,1'b1,4'hC,3'h4,4'hA,8'h33,1'b1},
        '{8'h90,8'h10,8'h05,1'b1,4'h2,3'h1,4'h4,8'h0B,1'b0},
        '{8'h9F,8'h05,8'h05,1'b1,4'h3,3'h1,4'h4,8'hFF,1'b1},
        '{8'h96,8'h05,8'h06,1'b0,4'h2,3'h2,4'h7,8'hFF,1'b1},
        '{8'h9E,8'h10,8'h05,1'b1,4'h3,3'h2,4'h7,8'h0A,1'b0},
        '{8'hD6,8'h00,8'h00,1'b1,4'h2,3'h3,4'h7,8'h00,1'b0},
        '{8'hDE,8'h00,8'h00,1'b1,4'h3,3'h3,4'h7,8'hFF,1'b1},
        '{8'hA1,8'hF0,8'h3C,1'b1,4'h4,3'h1,4'h4,8'h30,1'b0},
        '{8'hAA,8'hF0,8'h3C,1'b1,4'h5,3'h1,4'h4,8'hCC,1'b0},
        '{8'hB3,8'hF0,8'h3C,1'b1,4'h6,3'h1,4'h4,8'hFC,1'b0},
        '{8'hBC,8'h05,8'h06,1'b0,4'h7,3'h1,4'h4,8'h05,1'b1},
        '{8'hA6,8'hF0,8'h3C,1'b1,4'h4,3'h2,4'h7,8'h30,1'b0},
        '{8'hBE,8'h10,8'h05,1'b1,4'h7,3'h2,4'h7,8'h10,1'b0},
        '{8'hE6,8'hF0,8'h3C,1'b1,4'h4,3'h3,4'h7,8'h30,1'b0},
        '{8'hEE,8'hF0,8'h3C,1'b1,4'h5,3'h3,4'h7,8'hCC,1'b0},
        '{8'hF6,8'hF0,8'h3C,1'b1,4'h6,3'h3,4'h7,8'hFC,1'b0},
        '{8'hFE,8'h05,8'h06,1'b0,4'h7,3'h3,4'h7,8'h05,1'b1},
        '{8'h07,8'h81,8'h00,1'b0,4'h8,3'h0,4'h4,8'h03,1'b1},
        '{8'h17,8'h81,8'h00,1'b0,4'hA,3'h0,4'h4,8'h02,1'b1},
        '{8'h0F,8'h81,8'h00,1'b0,4'h9,3'h0,4'h4,8'hC0,1'b1},
        '{8'h1F,8'h81,8'h00,1'b0,4'hB,3'h0,4'h4,8'h40,1'b1}
    };

    fetch_model feed_u (.clock(clock), .rst_n(rst_n), .load(load), .ld_opcode(ld_opcode), .ld_acc(ld_acc),
        .ld_operand(ld_operand), .ld_carry(ld_carry), .ld_cond(ld_cond), .op_valid(op_valid), .opcode(opcode),
        .acc_in(acc_in), .operand_in(operand_in), .flags_in(flags_in), .cond_met(cond_met));
    cpu8_alu_logic_rotate_decode dut_u (.clock(clock), .rst_n(rst_n), .op_valid(op_valid), .opcode(opcode),
        .cond_met(cond_met), .acc_in(acc_in), .operand_in(operand_in), .flags_in(flags_in),
        .dec_valid(dec_valid), .dec(dec), .acc_out(acc_out), .flags_out(flags_out));

    // Clock at 100 MHz
    initial begin
        forever #5 clock = ~clock;
    end

    // Load one opcode, then wait at falling edges for its answer
    task automatic issue(input logic [7:0] o, a, b, input logic c, k);
        int n;
        n = 0;
        @(posedge clock);
        {load, ld_opcode, ld_acc, ld_operand, ld_carry, ld_cond} <= {1'b1, o, a, b, c, k};
        @(posedge clock);
        load <= 1'b0;
        do @(negedge clock); while (dec_valid !== 1'b1 && n++ < 5);
        `CHK("dec_valid", 1'b1, dec_valid)
    endtask

    // Counts, verdict and end of run
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (3000) @(posedge clock);
        bad_count++;
        test_done;
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            issue(rows[i].opc, rows[i].a, rows[i].b, rows[i].c, 1'b0);
            `CHK("op", rows[i].op, dec.op)
            `CHK("src", rows[i].src, dec.src)
            `CHK("cycles", rows[i].cyc, dec.cycles)
            `CHK("acc_out", rows[i].r, acc_out)
            `CHK("carry", rows[i].co, flags_out.carry)
        end
        $display("test table done");
        for (int s = 0; s < 8; s++) begin
            issue(8'hA0 | 8'(s), 8'hF0, 8'h3C, 1'b0, 1'b0);
            `CHK("source_field", 3'(s), dec.source_field)
            `CHK("cycles", (s == 6) ? 4'h7 : 4'h4, dec.cycles)
        end
        $display("test register field done");
        issue(8'hC8, 8'h00, 8'h00, 1'b0, 1'b1);
        `CHK("cond taken", 4'hC, dec.cycles)
        issue(8'hD0, 8'h00, 8'h00, 1'b0, 1'b0);
        `CHK("cond not taken", 4'h6, dec.cycles)
        issue(8'h00, 8'h5A, 8'h00, 1'b0, 1'b0);
        `CHK("unknown", 1'b0, dec.known)
        $display("test condition and unknown done");
        @(posedge clock);
        {load, ld_opcode, ld_acc, ld_carry} <= {1'b1, 8'h07, 8'h81, 1'b0};
        @(posedge clock);
        ld_opcode <= 8'h0F;
        @(posedge clock);
        load <= 1'b0;
        @(negedge clock);
        `CHK("first acc", 8'h03, acc_out)
        @(negedge clock);
        `CHK("second valid", 1'b1, dec_valid)
        `CHK("second acc", 8'hC0, acc_out)
        $display("test back to back done");
        @(posedge clock);
        rst_n <= 1'b0;
        @(negedge clock);
        `CHK("reset acc", 8'h00, acc_out)
        `CHK("reset dec", '0, dec)
        @(posedge clock);
        rst_n <= 1'b1;
        issue(8'h90, 8'h05, 8'h05, 1'b0, 1'b0);
        `CHK("acc after reset", 8'h00, acc_out)
        `CHK("flags after reset", 4'h6, flags_out)
        $display("test reset done");
        test_done;
    end
endmodule
